/* File: cta_pkg.sv */
package cta_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int unsigned CODE_W     = 14;      // 16384 code steps
  localparam int unsigned NUM_CH     = 8;       // 8 channels
  localparam int unsigned CH_W       = 3;
  localparam int unsigned CNT_W      = 5;
  localparam logic [4:0]  ALARM_EDGE = 5'h10;   // 16th falling edge
  localparam logic [4:0]  EDGE_MAX   = 5'h1f;

  localparam logic [CODE_W-1:0] THR_HI_RST = 14'h3fff;
  localparam logic [CODE_W-1:0] THR_LO_RST = 14'h0000;
  localparam logic [CODE_W-1:0] HYS_RST    = 14'h0000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [CODE_W-1:0] thr;
    logic [CODE_W-1:0] hys;
  } cta_limit_t;

  typedef struct packed {
    logic [NUM_CH-1:0] hi;
    logic [NUM_CH-1:0] lo;
  } cta_flags_t;

endpackage

/* File: cta_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - one alarm pin, loaded with the OR of all tripped flags on each 16th falling edge
// - alarm pin changes only on 16th falling serial clock edge
// - each channel has high and low alarm, own threshold and hysteresis
// - high alarm activates when code exceeds threshold plus hysteresis
// - high alarm clears when code at or below threshold-hysteresis-2
// - low alarm activates when code below threshold-hysteresis-1
// - low alarm clears when code at or above threshold+hysteresis+1
// - active flag follows the alarm condition
// - tripped flag latches, clears only when flag register is read
// - codes are straight binary on every channel and range
// - codes are 14 bits, one step is span over 16384
// - eight monitored channels
module cta_top (
  input  wire logic                         sys_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         sclk_i,
  input  wire logic                         csn_i,
  input  wire logic                         code_valid_i,
  input  wire logic [cta_pkg::CH_W-1:0]     code_ch_i,
  input  wire logic [cta_pkg::CODE_W-1:0]   code_i,
  input  wire cta_pkg::cta_limit_t [cta_pkg::NUM_CH-1:0] hi_lim_i,
  input  wire cta_pkg::cta_limit_t [cta_pkg::NUM_CH-1:0] lo_lim_i,
  input  wire logic                         trip_hi_rd_i,
  input  wire logic                         trip_lo_rd_i,
  output logic                              alarm_o,
  output cta_pkg::cta_flags_t               active_o,
  output cta_pkg::cta_flags_t               tripped_o
);
  import cta_pkg::*;

  // ************************************************************
  // serial clock and select synchronisers
  // ************************************************************
  logic [1:0]       sclk_sync_q, sclk_sync_d;
  logic [1:0]       csn_sync_q,  csn_sync_d;
  logic             sclk_last_q, sclk_last_d;
  logic [CNT_W-1:0] edge_cnt_q,  edge_cnt_d;
  logic             fall;

  always_comb begin
    sclk_sync_d = {sclk_sync_q[0], sclk_i};
    csn_sync_d  = {csn_sync_q[0], csn_i};
    sclk_last_d = sclk_sync_q[1];
    fall        = sclk_last_q & ~sclk_sync_q[1] & ~csn_sync_q[1];
    edge_cnt_d  = edge_cnt_q;
    if (csn_sync_q[1]) begin
      edge_cnt_d = '0;
    end else if (fall && edge_cnt_q != EDGE_MAX) begin
      edge_cnt_d = edge_cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sclk_sync_q <= 2'h0;
      csn_sync_q  <= 2'h3;
      sclk_last_q <= 1'b0;
      edge_cnt_q  <= '0;
    end else begin
      sclk_sync_q <= sclk_sync_d;
      csn_sync_q  <= csn_sync_d;
      sclk_last_q <= sclk_last_d;
      edge_cnt_q  <= edge_cnt_d;
    end
  end

  // ************************************************************
  // per-channel comparators and flags
  // ************************************************************
  // 16-bit arithmetic so threshold +/- hysteresis never wraps;
  // limits below zero or above full scale simply never trigger
  logic [NUM_CH-1:0] act_hi_q, act_hi_d, act_lo_q, act_lo_d;
  logic [NUM_CH-1:0] trip_hi_q, trip_hi_d, trip_lo_q, trip_lo_d;
  logic              alarm_q, alarm_d;

  always_comb begin
    logic signed [CODE_W+1:0] c, hs, hc, ls, lc;
    c  = '0;
    hs = '0;
    hc = '0;
    ls = '0;
    lc = '0;
    act_hi_d  = act_hi_q;
    act_lo_d  = act_lo_q;
    // reading a flag register clears it, but a new trip wins
    trip_hi_d = trip_hi_rd_i ? '0 : trip_hi_q;
    trip_lo_d = trip_lo_rd_i ? '0 : trip_lo_q;
    for (int i = 0; i < NUM_CH; i++) begin
      if (code_valid_i && code_ch_i == CH_W'(i)) begin
        // straight binary: code is plain unsigned
        c  = {2'b00, code_i};
        hs = {2'b00, hi_lim_i[i].thr} + {2'b00, hi_lim_i[i].hys};
        hc = {2'b00, hi_lim_i[i].thr} - {2'b00, hi_lim_i[i].hys}
             - 16'sd2;
        ls = {2'b00, lo_lim_i[i].thr} - {2'b00, lo_lim_i[i].hys}
             - 16'sd1;
        lc = {2'b00, lo_lim_i[i].thr} + {2'b00, lo_lim_i[i].hys}
             + 16'sd1;
        if (c > hs) begin
          act_hi_d[i] = 1'b1;
        end else if (c <= hc) begin
          act_hi_d[i] = 1'b0;
        end
        if (c < ls) begin
          act_lo_d[i] = 1'b1;
        end else if (c >= lc) begin
          act_lo_d[i] = 1'b0;
        end
        if (act_hi_d[i]) begin
          trip_hi_d[i] = 1'b1;
        end
        if (act_lo_d[i]) begin
          trip_lo_d[i] = 1'b1;
        end
      end
    end
    alarm_d = alarm_q;
    // pin only moves on the 16th falling edge of a frame
    if (fall && edge_cnt_q == ALARM_EDGE - CNT_W'(1)) begin
      alarm_d = |{trip_hi_q, trip_lo_q};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      act_hi_q  <= '0;
      act_lo_q  <= '0;
      trip_hi_q <= '0;
      trip_lo_q <= '0;
      alarm_q   <= 1'b0;
    end else begin
      act_hi_q  <= act_hi_d;
      act_lo_q  <= act_lo_d;
      trip_hi_q <= trip_hi_d;
      trip_lo_q <= trip_lo_d;
      alarm_q   <= alarm_d;
    end
  end

  always_comb begin
    alarm_o      = alarm_q;
    active_o.hi  = act_hi_q;
    active_o.lo  = act_lo_q;
    tripped_o.hi = trip_hi_q;
    tripped_o.lo = trip_lo_q;
  end

endmodule

/* File: cta_top_monitor.sv */
`timescale 1ns/100ps
// ****
// checker
// ****
module cta_top_monitor (
  input wire logic                 sys_clk_i,
  input wire logic                 rstn_i,
  input wire logic                 csn_i,
  input wire logic                 code_valid_i,
  input wire logic [2:0]           code_ch_i,
  input wire logic [13:0]          code_i,
  input wire cta_pkg::cta_limit_t [7:0] hi_lim_i,
  input wire cta_pkg::cta_limit_t [7:0] lo_lim_i,
  input wire logic                 trip_hi_rd_i,
  input wire logic                 trip_lo_rd_i,
  input wire logic                 alarm_o,
  input wire cta_pkg::cta_flags_t  active_o,
  input wire cta_pkg::cta_flags_t  tripped_o
);
  import cta_pkg::*;
  int c, hs, hc, ls, lc;
  assign c = int'(code_i);
  assign hs = int'(hi_lim_i[code_ch_i].thr) + int'(hi_lim_i[code_ch_i].hys);
  assign hc = int'(hi_lim_i[code_ch_i].thr)
              - int'(hi_lim_i[code_ch_i].hys) - 2;
  assign ls = int'(lo_lim_i[code_ch_i].thr)
              - int'(lo_lim_i[code_ch_i].hys) - 1;
  assign lc = int'(lo_lim_i[code_ch_i].thr)
              + int'(lo_lim_i[code_ch_i].hys) + 1;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_hi_set: assert property (
    code_valid_i && c > hs |=> active_o.hi[$past(code_ch_i)])
    else $error("hi set");
  a_hi_clr: assert property (
    code_valid_i && c <= hc |=> !active_o.hi[$past(code_ch_i)])
    else $error("hi clr");
  a_lo_set: assert property (
    code_valid_i && c < ls |=> active_o.lo[$past(code_ch_i)])
    else $error("lo set");
  a_lo_clr: assert property (
    code_valid_i && c >= lc |=> !active_o.lo[$past(code_ch_i)])
    else $error("lo clr");
  a_act_hold: assert property (
    !code_valid_i |=> $stable(active_o)) else $error("active moved");
  a_trip_hold: assert property (
    !code_valid_i && !trip_hi_rd_i && !trip_lo_rd_i |=> $stable(tripped_o))
    else $error("tripped moved");
  a_rd_clr: assert property (
    trip_hi_rd_i && !code_valid_i |=> tripped_o.hi == '0)
    else $error("no clear");
  a_alarm_idle: assert property (
    csn_i [*8] |=> $stable(alarm_o)) else $error("alarm moved while idle");
  cover property (trip_hi_rd_i);
  cover property ($rose(alarm_o));
  cover property (code_valid_i && c < ls);
endmodule

/* File: cta_host.sv */
`timescale 1ns/100ps
// ****
// host model: serial clock idles high, still outside frames
// ****
module cta_host (
  input  wire logic sys_clk_i,
  output logic      sclk_o,
  output logic      csn_o,
  output logic      hi_rd_o,
  output logic      lo_rd_o
);
  initial {sclk_o, csn_o, hi_rd_o, lo_rd_o} = 4'hc;
  task automatic frame();
    csn_o = 1'b0;
    repeat (16) begin
      #80 sclk_o = 1'b0;
      #80 sclk_o = 1'b1;
    end
    #80 csn_o = 1'b1;
  endtask
  task automatic rd(input logic h, input logic l);
    @(posedge sys_clk_i) #1;
    {hi_rd_o, lo_rd_o} = {h, l};
    @(posedge sys_clk_i) #1;
    {hi_rd_o, lo_rd_o} = 2'h0;
  endtask
endmodule

/* File: cta_top_tb.sv */
`timescale 1ns/100ps
module cta_top_tb;
  import cta_pkg::*;
  logic clk, rstn, sclk, csn, vld, hrd, lrd, alarm;
  logic [2:0] ch;
  logic [13:0] code;
  cta_limit_t [7:0] hl, ll;
  cta_flags_t act, trp, ea, et;
  int fail_count, n_compared, k;
  cta_top cta_top_i (.sys_clk_i(clk), .rstn_i(rstn), .sclk_i(sclk),
    .csn_i(csn), .code_valid_i(vld), .code_ch_i(ch), .code_i(code),
    .hi_lim_i(hl), .lo_lim_i(ll), .trip_hi_rd_i(hrd), .trip_lo_rd_i(lrd),
    .alarm_o(alarm), .active_o(act), .tripped_o(trp));
  cta_host cta_host_i (.sys_clk_i(clk), .sclk_o(sclk), .csn_o(csn),
    .hi_rd_o(hrd), .lo_rd_o(lrd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic [2:0] c, input logic [13:0] v);
    int x;
    x = int'(v);
    @(posedge clk) #1;
    {vld, ch, code} = {1'b1, c, v};
    if (x > int'(hl[c].thr) + int'(hl[c].hys)) {ea.hi[c], et.hi[c]} = 2'h3;
    if (x <= int'(hl[c].thr) - int'(hl[c].hys) - 2) ea.hi[c] = 1'b0;
    if (x < int'(ll[c].thr) - int'(ll[c].hys) - 1) {ea.lo[c], et.lo[c]} = 2'h3;
    if (x >= int'(ll[c].thr) + int'(ll[c].hys) + 1) ea.lo[c] = 1'b0;
    // a flag still active in its hysteresis band re-trips on every code
    if (ea.hi[c]) et.hi[c] = 1'b1;
    if (ea.lo[c]) et.lo[c] = 1'b1;
    @(posedge clk) #1;
    vld = 1'b0;
    chk({act, trp}, {ea, et});
  endtask
  task automatic clr(input logic h, input logic l);
    cta_host_i.rd(h, l);
    if (h) et.hi = '0;
    if (l) et.lo = '0;
    chk(trp, et);
  endtask
  task automatic frm();
    cta_host_i.frame();
    repeat (6) @(posedge clk);
    chk(alarm, |et);
  endtask
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  initial begin
    {rstn, vld, ch, code, ea, et, hl, ll} = '0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(32'he92e));
    for (k = 0; k < 8; k++) begin
      hl[k] = {14'(8192 + $urandom_range(4000)), 14'($urandom_range(63))};
      ll[k] = {14'(2048 + $urandom_range(4000)), 14'($urandom_range(63))};
    end
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    send(0, hl[0].thr + hl[0].hys);
    send(0, hl[0].thr + hl[0].hys + 14'h0001);
    send(0, hl[0].thr - hl[0].hys - 14'h0001);
    send(0, hl[0].thr - hl[0].hys - 14'h0002);
    send(1, ll[1].thr - ll[1].hys - 14'h0001);
    send(1, ll[1].thr - ll[1].hys - 14'h0002);
    send(1, ll[1].thr + ll[1].hys);
    send(1, ll[1].thr + ll[1].hys + 14'h0001);
    frm();
    clr(1'b1, 1'b1);
    chk(alarm, 1'b1);
    frm();
    repeat (300) begin
      send(3'($urandom_range(7)), 14'($urandom_range(16383)));
      if ($urandom_range(15) == 0) clr(1'b1, 1'b0);
    end
    frm();
    wrap_up();
  end
endmodule
bind cta_top cta_top_monitor cta_top_monitor_i (.*);
